// ### verilog/csc_consts.vh
// constants for the supply command layer: command codes, field positions, reset values, timings
// assumes a 100 MHz core clock
`ifndef CSC_CONSTS_VH
`define CSC_CONSTS_VH
`define CSC_CMD_ONOFF      16'h0000
`define CSC_CMD_VSET       16'h0020
`define CSC_CMD_ISET       16'h0030
`define CSC_CMD_DATE       16'h0086
`define CSC_CMD_SER_DATE   16'h0087
`define CSC_CMD_SER_SEQ    16'h0088
`define CSC_CMD_SCALE      16'h00C0
`define CSC_CMD_STATUS     16'h00C1
`define CSC_CMD_SETUP      16'h00C2
`define CSC_REQ_ID         29'h000C0100
`define CSC_RSP_ID         29'h000C0000
`define CSC_ID_BASE_MSK    29'h1FFFFF00
`define CSC_LEN_READ       4'h2
`define CSC_LEN_WRITE      4'h4
`define CSC_LEN_CODE       4'h2
`define CSC_LEN_ONE        4'h1
`define CSC_LEN_TWO        4'h2
`define CSC_LEN_SIX        4'h6
`define CSC_SETUP_RST      16'h0002
`define CSC_ONOFF_ON       8'h01
`define CSC_ONOFF_OFF      8'h00
`define CSC_BIT_BUSCTRL    0
`define CSC_PWRUP_LO       1
`define CSC_PWRUP_HI       2
`define CSC_COMMIT_LO      8
`define CSC_COMMIT_HI      9
`define CSC_BIT_NOSAVE     10
`define CSC_PWRUP_OFF      2'h0
`define CSC_PWRUP_ON       2'h1
`define CSC_PWRUP_PREV     2'h2
`define CSC_ENC_RSVD       2'h3
`define CSC_COMMIT_NOW     2'h0
`define CSC_COMMIT_1MIN    2'h1
`define CSC_COMMIT_10MIN   2'h2
`define CSC_CLK_MHZ        100
`define CSC_DELAY1_S       60
`define CSC_DELAY10_S      600
`define CSC_US_PER_S       36'd1000000
`endif

// ### verilog/csc_command_regs.v
// command and register layer of a bus-controlled supply: decodes received CAN frames
// and builds answer frames. assumes a CAN controller delivers whole extended frames.
//
// Contract
// RULE_01: date read returns six ASCII digits YYMMDD
// RULE_02: serial reads return date, then sequence digits
// RULE_03: scale byte0: volt code low, amp high
// RULE_04: scale bytes 1-3 nibbles; bytes 4-5 reserved
// RULE_05: scale code 0 unsupported, 4..9 multipliers
// RULE_06: status bit0 reports sharing master
// RULE_07: status bits 1,2 report converter health
// RULE_08: status bits 4,5,6 load, init, nvm error
// RULE_09: unsupported status and setup bits read zero
// RULE_10: setup bit0 selects bus or analogue control
// RULE_11: setup bits1-2 select power-up on/off value
// RULE_12: high bits0-1 select nvm commit delay
// RULE_13: high bit2 suppresses nvm saving
// RULE_14: extended frames at 250 kbit/s
// RULE_15: master writes code then parameter, low first
// RULE_16: read is code only; answer echoes code
// RULE_17: answers use the response identifier base
// RULE_18: code 0x0020 is voltage setpoint, 0.01 V
// RULE_19: master enables bus control via setup write
// RULE_20: on/off reads 0x01 when commanded on
// RULE_21: master reads back and rewrites mismatches
// RULE_22: reserved encodings written are ignored
`include "csc_consts.vh"
`timescale 1ns/1ns
`default_nettype none

module csc_command_regs #(
    parameter [7:0]  UNIT_ADDR     = 8'h00,
    parameter [47:0] BUILD_DATE    = 48'h313830313031,
    parameter [47:0] SERIAL_SEQ    = 48'h303030303031,
    parameter [47:0] SCALE_DESC    = 48'h000000007557,
    // 36 bits: the ten-minute count does not fit in 32
    parameter [35:0] DELAY1_CYC    = `CSC_DELAY1_S * `CSC_CLK_MHZ * `CSC_US_PER_S,
    parameter [35:0] DELAY10_CYC   = `CSC_DELAY10_S * `CSC_CLK_MHZ * `CSC_US_PER_S
) (
    input  wire        core_clk,
    input  wire        sys_rst,
    input  wire        rxValid,
    input  wire        rxExtended,
    input  wire [28:0] rxId,
    input  wire [3:0]  rxLen,
    input  wire [63:0] rxData,
    input  wire        txReady,
    output reg         txValid,
    output reg  [28:0] txId,
    output reg  [3:0]  txLen,
    output reg  [63:0] txData,
    input  wire        shareMaster,
    input  wire        secondaryOutputGood,
    input  wire        primaryStageGood,
    input  wire        dummyLoadActive,
    input  wire        initActive,
    input  wire        nvmAccessError,
    input  wire        storedOnOff,
    output reg         busControl,
    output reg         outputOn,
    output reg  [15:0] outVoltSetpoint,
    output reg  [15:0] outAmpSetpoint,
    output reg         nvmCommit
);

    // ****************************************
    // decode helpers
    // ****************************************
    function isReq;
        input [28:0] id;
        input        ext;
        begin
            isReq = ext && ((id & `CSC_ID_BASE_MSK) == `CSC_REQ_ID)            // [RULE_14]
                    && (id[7:0] == UNIT_ADDR);
        end
    endfunction

    function [15:0] cmdOf;
        input [63:0] d;
        begin
            cmdOf = {d[15:8], d[7:0]};                                          // [RULE_15]
        end
    endfunction

    // ****************************************
    // state
    // ****************************************
    reg  [15:0] setupWord_ff;
    reg  [35:0] idleCnt_ff;
    reg         dirty_ff;
    reg         pwrupDone_ff;
    reg         pendTx_ff;

    wire        hit      = rxValid && isReq(rxId, rxExtended);
    wire [15:0] cmd      = cmdOf(rxData);
    wire [15:0] param    = {rxData[31:24], rxData[23:16]};
    wire        isWrite  = hit && (rxLen == `CSC_LEN_WRITE);
    wire        isRead   = hit && (rxLen == `CSC_LEN_READ);                    // [RULE_16]
    wire [1:0]  pwrupSel = setupWord_ff[`CSC_PWRUP_HI:`CSC_PWRUP_LO];
    wire [1:0]  commitSel = setupWord_ff[`CSC_COMMIT_HI:`CSC_COMMIT_LO];
    wire        saveOff  = setupWord_ff[`CSC_BIT_NOSAVE];
    wire        busCtl   = setupWord_ff[`CSC_BIT_BUSCTRL];

    // status: only documented bits are driven, others zero
    wire [15:0] statusWord = {9'h000, nvmAccessError, initActive,              // [RULE_08]
                              dummyLoadActive, 1'b0, primaryStageGood,         // [RULE_07]
                              secondaryOutputGood, shareMaster};               // [RULE_06] [RULE_09]

    // ****************************************
    // setup word write with reserved-field filter
    // ****************************************
    reg [15:0] nxt_setupWord;
    always @*
    begin
        nxt_setupWord = setupWord_ff;
        if (isWrite && cmd == `CSC_CMD_SETUP)
        begin
            nxt_setupWord[`CSC_BIT_BUSCTRL] = param[`CSC_BIT_BUSCTRL];          // [RULE_10]
            if (param[`CSC_PWRUP_HI:`CSC_PWRUP_LO] != `CSC_ENC_RSVD)             // [RULE_22]
                nxt_setupWord[`CSC_PWRUP_HI:`CSC_PWRUP_LO] = param[`CSC_PWRUP_HI:`CSC_PWRUP_LO]; // [RULE_11]
            if (param[`CSC_COMMIT_HI:`CSC_COMMIT_LO] != `CSC_ENC_RSVD)           // [RULE_22]
                nxt_setupWord[`CSC_COMMIT_HI:`CSC_COMMIT_LO] = param[`CSC_COMMIT_HI:`CSC_COMMIT_LO]; // [RULE_12]
            nxt_setupWord[`CSC_BIT_NOSAVE] = param[`CSC_BIT_NOSAVE];            // [RULE_13]
        end
    end

    always @(posedge core_clk)
    begin
        if (sys_rst)
            setupWord_ff <= `CSC_SETUP_RST;
        else
            setupWord_ff <= nxt_setupWord;                                      // [RULE_09]
    end

    // ****************************************
    // control outputs and setpoints
    // ****************************************
    wire paramChange = isWrite && (cmd == `CSC_CMD_VSET || cmd == `CSC_CMD_ISET
                       || cmd == `CSC_CMD_ONOFF || cmd == `CSC_CMD_SETUP);

    always @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            busControl      <= 1'b0;
            outputOn        <= 1'b0;
            outVoltSetpoint <= 16'h0000;
            outAmpSetpoint  <= 16'h0000;
            pwrupDone_ff    <= 1'b0;
        end
        else
        begin
            busControl   <= nxt_setupWord[`CSC_BIT_BUSCTRL];                    // [RULE_10]
            pwrupDone_ff <= 1'b1;
            // power-up value taken once, the cycle after reset release
            if (!pwrupDone_ff)
            begin
                case (pwrupSel)                                                 // [RULE_11]
                    `CSC_PWRUP_OFF:  outputOn <= 1'b0;
                    `CSC_PWRUP_ON:   outputOn <= 1'b1;
                    `CSC_PWRUP_PREV: outputOn <= storedOnOff;
                    default:         outputOn <= 1'b1;
                endcase
            end
            else if (isWrite && cmd == `CSC_CMD_ONOFF && busCtl)
                outputOn <= param[0];
            if (isWrite && cmd == `CSC_CMD_VSET && busCtl)
                outVoltSetpoint <= param;                                       // [RULE_18]
            if (isWrite && cmd == `CSC_CMD_ISET && busCtl)
                outAmpSetpoint <= param;
        end
    end

    // ****************************************
    // nonvolatile commit timing
    // ****************************************
    // a change restarts the quiet-time count; commit fires when the count expires
    always @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            dirty_ff   <= 1'b0;
            idleCnt_ff <= 36'h000000000;
            nvmCommit  <= 1'b0;
        end
        else
        begin
            nvmCommit <= 1'b0;
            if (paramChange)
            begin
                dirty_ff   <= !saveOff;                                         // [RULE_13]
                idleCnt_ff <= 36'h000000000;
            end
            else if (dirty_ff)
            begin
                idleCnt_ff <= idleCnt_ff + 36'h000000001;
                if ((commitSel == `CSC_COMMIT_NOW)                               // [RULE_12]
                    || (commitSel == `CSC_COMMIT_1MIN && idleCnt_ff >= DELAY1_CYC - 36'h000000001)
                    || (commitSel == `CSC_COMMIT_10MIN && idleCnt_ff >= DELAY10_CYC - 36'h000000001))
                begin
                    nvmCommit <= !saveOff;
                    dirty_ff  <= 1'b0;
                end
            end
        end
    end

    // ****************************************
    // read answers
    // ****************************************
    reg [47:0] rdVal;
    reg [3:0]  rdLen;
    reg        rdOk;
    reg        rdSwap;
    // only text strings are stored first-character-high; the scale descriptor is already byte0-low
    always @*
    begin
        rdVal  = 48'h000000000000;
        rdLen  = `CSC_LEN_TWO;
        rdOk   = 1'b1;
        rdSwap = 1'b0;
        case (cmd)
            `CSC_CMD_DATE:     begin rdVal = BUILD_DATE; rdLen = `CSC_LEN_SIX; rdSwap = 1'b1; end // [RULE_01]
            `CSC_CMD_SER_DATE: begin rdVal = BUILD_DATE; rdLen = `CSC_LEN_SIX; rdSwap = 1'b1; end // [RULE_02]
            `CSC_CMD_SER_SEQ:  begin rdVal = SERIAL_SEQ; rdLen = `CSC_LEN_SIX; rdSwap = 1'b1; end // [RULE_02]
            `CSC_CMD_SCALE:    begin rdVal = {16'h0000, SCALE_DESC[31:0]}; rdLen = `CSC_LEN_SIX; end // [RULE_03] [RULE_04] [RULE_05]
            `CSC_CMD_STATUS:   rdVal[15:0] = statusWord;
            `CSC_CMD_SETUP:    rdVal[15:0] = setupWord_ff;
            `CSC_CMD_VSET:     rdVal[15:0] = outVoltSetpoint;
            `CSC_CMD_ISET:     rdVal[15:0] = outAmpSetpoint;
            `CSC_CMD_ONOFF:    begin rdVal[7:0] = outputOn ? `CSC_ONOFF_ON : `CSC_ONOFF_OFF; rdLen = `CSC_LEN_ONE; end // [RULE_20]
            default:           rdOk = 1'b0;
        endcase
    end

    // byte lanes: byte0 of a string travels first, i.e. in the lowest data lane
    function [47:0] laneOrder;
        input [47:0] v;
        input [3:0]  n;
        begin
            if (n == `CSC_LEN_SIX)
                laneOrder = {v[7:0], v[15:8], v[23:16], v[31:24], v[39:32], v[47:40]};
            else
                laneOrder = v;
        end
    endfunction

    // ****************************************
    // transmit holding register
    // ****************************************
    // a request arriving while an answer is still pending is dropped
    always @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            txValid   <= 1'b0;
            txId      <= 29'h00000000;
            txLen     <= 4'h0;
            txData    <= 64'h0000000000000000;
            pendTx_ff <= 1'b0;
        end
        else
        begin
            if (txValid && txReady)
            begin
                txValid   <= 1'b0;
                pendTx_ff <= 1'b0;
            end
            else if (isRead && rdOk && !pendTx_ff)
            begin
                txValid   <= 1'b1;
                pendTx_ff <= 1'b1;
                txId      <= `CSC_RSP_ID | {21'h000000, UNIT_ADDR};             // [RULE_17]
                txLen     <= `CSC_LEN_CODE + rdLen;                             // [RULE_16]
                txData    <= {rdSwap ? laneOrder(rdVal, rdLen) : rdVal, rxData[15:0]};
            end
        end
    end

endmodule // csc_command_regs

`default_nettype wire

// ### bench/csc_command_regs_chk.sv
// port checker for the supply command layer
// assumes unit address 0; bound to the design at the foot
`include "csc_consts.vh"
`timescale 1ns/1ns
`default_nettype none
module csc_command_regs_chk (
    input wire logic        core_clk,
    input wire logic        sys_rst,
    input wire logic        rxValid,
    input wire logic        rxExtended,
    input wire logic [28:0] rxId,
    input wire logic [3:0]  rxLen,
    input wire logic [63:0] rxData,
    input wire logic        txReady,
    input wire logic        txValid,
    input wire logic [28:0] txId,
    input wire logic [3:0]  txLen,
    input wire logic [63:0] txData,
    input wire logic        busControl,
    input wire logic [15:0] outVoltSetpoint,
    input wire logic        nvmCommit
);
    wire take = rxValid && rxExtended && rxId == `CSC_REQ_ID;
    wire wrV  = take && rxLen == 4'h4 && rxData[15:0] == `CSC_CMD_VSET;
    default clocking @(posedge core_clk); endclocking
    default disable iff (sys_rst);
    txid_base_a: assert property (txValid |-> txId == `CSC_RSP_ID) else $error("bad answer id");
    tx_hold_a: assert property (txValid && !txReady |=> txValid && $stable(txData) && $stable(txLen))
        else $error("answer dropped early");
    rd_echo_a: assert property (take && rxLen == 4'h2 && rxData[15:0] == `CSC_CMD_STATUS && !txValid
        |=> txValid && txLen == 4'h4 && txData[15:0] == `CSC_CMD_STATUS) else $error("no status answer");
    scale_rsvd_a: assert property (txValid && txData[15:0] == `CSC_CMD_SCALE
        |-> txData[63:48] == 16'h0000 && txLen == 4'h8) else $error("bad scale answer");
    vset_write_a: assert property (wrV && busControl |=> outVoltSetpoint == $past(rxData[31:16]))
        else $error("setpoint not taken");
    vset_hold_a: assert property (wrV && !busControl |=> $stable(outVoltSetpoint))
        else $error("setpoint moved");
    commit_pulse_a: assert property (nvmCommit |=> !nvmCommit) else $error("commit too long");
    foreign_id_a: assert property (rxValid && rxId[7:0] != 8'h00 && !txValid |=> !txValid)
        else $error("answered other unit");
    bus_ctrl_a: assert property (take && rxLen == 4'h4 && rxData[15:0] == `CSC_CMD_SETUP
        |=> busControl == $past(rxData[16])) else $error("control bit wrong");
endmodule // csc_command_regs_chk
bind csc_command_regs csc_command_regs_chk chk (.*);
`default_nettype wire

// ### bench/csc_can_host.sv
// model of the CAN controller that faces the command layer
// assumes the bench seeds the random source
`timescale 1ns/1ns
`default_nettype none
module csc_can_host (
    input  wire logic        core_clk,
    input  wire logic        txValid,
    input  wire logic [28:0] txId,
    input  wire logic [3:0]  txLen,
    input  wire logic [63:0] txData,
    output var  logic        rxValid,
    output var  logic        rxExtended,
    output var  logic [28:0] rxId,
    output var  logic [3:0]  rxLen,
    output var  logic [63:0] rxData,
    output var  logic        txReady
);
    int          rspCnt = 0;
    logic [28:0] gotId;
    logic [3:0]  gotLen;
    logic [63:0] gotData;
    initial {rxValid, rxExtended, rxId, rxLen, rxData, txReady} = '0;
    // random stalls so answers must stand until taken
    always @(posedge core_clk)
    begin
        txReady <= ($urandom % 3) != 0;
        if (txValid && txReady)
        begin
            rspCnt  <= rspCnt + 1;
            {gotId, gotLen, gotData} <= {txId, txLen, txData};
        end
    end
    task send(input logic e, input logic [28:0] i, input logic [3:0] l, input logic [63:0] d);
        @(posedge core_clk);
        {rxValid, rxExtended, rxId, rxLen, rxData} <= {1'b1, e, i, l, d};
        @(posedge core_clk);
        rxValid <= 1'b0;
        rxData  <= ~d;
    endtask
endmodule // csc_can_host
`default_nettype wire

// ### bench/can_supply_command_registers_tb.sv
// self-checking bench for the supply command layer
// assumes the checker binds itself; short commit delays
`include "csc_consts.vh"
`timescale 1ns/1ns
`default_nettype none
module can_supply_command_registers_tb;
    logic core_clk = 0, sys_rst = 1;
    logic [5:0] st = 0;
    wire rxValid, rxExtended, txReady, txValid, busControl, outputOn, nvmCommit;
    wire [28:0] rxId, txId;
    wire [3:0] rxLen, txLen;
    wire [63:0] rxData, txData;
    wire [15:0] outVoltSetpoint, outAmpSetpoint;
    int num_errors = 0, samples_checked = 0, n, commits = 0, m;
    int w1[4] = '{0, 10, 25, 60}, w2[4] = '{5, 30, 40, 60};
    logic [15:0] v, cfg[4] = '{16'h0003, 16'h0103, 16'h0203, 16'h0403};
    always #5 core_clk = ~core_clk;
    always @(posedge core_clk) if (nvmCommit) commits <= commits + 1;
    csc_command_regs #(.SCALE_DESC(48'hAAAA00060857), .DELAY1_CYC(20), .DELAY10_CYC(50)) uut (
        .core_clk(core_clk), .sys_rst(sys_rst), .rxValid(rxValid), .rxExtended(rxExtended),
        .rxId(rxId), .rxLen(rxLen), .rxData(rxData), .txReady(txReady), .txValid(txValid),
        .txId(txId), .txLen(txLen), .txData(txData), .shareMaster(st[0]), .secondaryOutputGood(st[1]),
        .primaryStageGood(st[2]), .dummyLoadActive(st[3]), .initActive(st[4]), .nvmAccessError(st[5]),
        .storedOnOff(1'b0), .busControl(busControl), .outputOn(outputOn), .outVoltSetpoint(outVoltSetpoint),
        .outAmpSetpoint(outAmpSetpoint), .nvmCommit(nvmCommit));
    csc_can_host host (.core_clk(core_clk), .txValid(txValid), .txId(txId), .txLen(txLen), .txData(txData),
        .rxValid(rxValid), .rxExtended(rxExtended), .rxId(rxId), .rxLen(rxLen), .rxData(rxData),
        .txReady(txReady));
    task chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task report_and_stop;
        if (num_errors == 0 && samples_checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task wr(input logic [15:0] c, input logic [15:0] p);
        host.send(1'b1, `CSC_REQ_ID, `CSC_LEN_WRITE, {32'h0, p, c});
        @(posedge core_clk);
    endtask
    task rd(input logic [15:0] c, input logic [3:0] l, input logic [47:0] d);
        logic [63:0] mk;
        mk = (64'h1 << (8 * l)) - 64'h1;
        n = host.rspCnt;
        host.send(1'b1, `CSC_REQ_ID, `CSC_LEN_READ, {48'h0, c});
        for (int k = 0; k < 40 && host.rspCnt == n; k++) @(posedge core_clk);
        if (host.rspCnt == n)
        begin
            num_errors++;
            report_and_stop;
        end
        chk("txId", host.gotId, `CSC_RSP_ID);
        chk("txLen", host.gotLen, l);
        chk("txData", host.gotData & mk, {d, c} & mk);
    endtask
    task quiet(input logic e, input logic [28:0] i, input logic [3:0] l, input logic [15:0] c);
        n = host.rspCnt;
        host.send(e, i, l, {48'h0, c});
        repeat (8) @(posedge core_clk);
        chk("dropped", 64'(host.rspCnt), 64'(n));
    endtask
    initial
    begin
        void'($urandom(35490));
        repeat (20) @(posedge core_clk);
        sys_rst <= 1'b0;
        repeat (3) @(posedge core_clk);
        chk("outputOn", outputOn, 1);
        rd(`CSC_CMD_SETUP, 4'h4, 48'h0002);
        rd(`CSC_CMD_ONOFF, 4'h3, 48'h01);
        rd(`CSC_CMD_DATE, 4'h8, 48'h313031303831);
        rd(`CSC_CMD_SER_DATE, 4'h8, 48'h313031303831);
        rd(`CSC_CMD_SER_SEQ, 4'h8, 48'h313030303030);
        rd(`CSC_CMD_SCALE, 4'h8, 48'h000000060857);
        wr(`CSC_CMD_VSET, 16'h15E0);
        quiet(1'b1, 29'h000C0101, `CSC_LEN_READ, `CSC_CMD_STATUS);
        quiet(1'b0, `CSC_REQ_ID, `CSC_LEN_READ, `CSC_CMD_STATUS);
        quiet(1'b1, `CSC_REQ_ID, `CSC_LEN_READ, 16'h0099);
        chk("vset analog", outVoltSetpoint, 0);
        wr(`CSC_CMD_SETUP, 16'h0003);
        for (int i = 0; i < 12; i++)
        begin
            st <= 6'($urandom);
            v = 16'($urandom);
            wr(`CSC_CMD_VSET, v);
            chk("outVoltSetpoint", outVoltSetpoint, v);
            rd(`CSC_CMD_VSET, 4'h4, v);
            rd(`CSC_CMD_STATUS, 4'h4, {st[5:3], 1'b0, st[2:0]});
        end
        wr(`CSC_CMD_ISET, 16'h0BB8);
        wr(`CSC_CMD_ONOFF, 16'h0000);
        chk("outAmpSetpoint", outAmpSetpoint, 16'h0BB8);
        chk("outputOn off", outputOn, 0);
        for (m = 0; m < 4; m++)
        begin
            wr(`CSC_CMD_SETUP, cfg[m]);
            repeat (120) @(posedge core_clk);
            n = commits;
            wr(`CSC_CMD_VSET, 16'h1000 + 16'(m));
            repeat (w1[m]) @(posedge core_clk);
            chk("commit early", 64'(commits), 64'(n));
            repeat (w2[m]) @(posedge core_clk);
            chk("commit", 64'(commits), 64'(n + (m < 3)));
        end
        wr(`CSC_CMD_SETUP, 16'h0306);
        rd(`CSC_CMD_SETUP, 4'h4, 48'h0002);
        report_and_stop;
    end
endmodule // can_supply_command_registers_tb
`default_nettype wire
